/* File: rtl/emu_hs_pkg.sv */
/*
 emulation access handshake package: states and control-word layout.
 assumes the host control register lives elsewhere; only its bits are here.
*/
// Summary of operation
// RULE1: emulator active: reset and interrupts serviced only in execution mode.
// RULE2: target applies reset before the emulator is activated.
// RULE3: host port accesses still answered while emulation halts execution.
// RULE4: during emulation halt, reset, interrupts, nmi and halt stay pending.
// RULE5: host and emulator accesses are never serialised or locked out.
// RULE6: request flag sets when the emulator needs access.
// RULE7: request set with interrupt enable raises the host interrupt.
// RULE8: host writing grant one clears interrupt and lets emulator proceed.
// RULE9: halt condition stops execution at once, whatever the grant flag.
// RULE10: emulator access waits until the host has set the grant flag.
// RULE11: request flag clears once the emulator no longer needs access.
// RULE12: request cleared with enable set raises the host interrupt again.
// RULE13: host clearing grant drops the interrupt raised by the release.
// RULE14: host may detect a halt by interrupt or by polling the request flag.
// RULE15: the handshake is optional for the host.
// RULE16: request flag read-only; grant, enable host-writable, reset zero.
package emu_hs_pkg;
   // bit positions inside the low host control word
   localparam int unsigned REQ_BIT   = 0;
   localparam int unsigned GRANT_BIT = 1;
   localparam int unsigned IRQEN_BIT = 2;
   localparam int unsigned CTRL_W    = 3;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_WAIT_GRANT,
      ST_ACCESS,
      ST_WAIT_UNGRANT
   } hs_state_e;
endpackage

/* File: rtl/emu_hs_if.sv */
/*
 interface carrying the event gate between the handshake and its gate module.
 assumes one clock domain, driven by the top.
*/
interface emu_hs_if;
   logic exec_mode;
   logic emu_active;
   logic rst_req;
   logic irq_req;
   logic nmi_req;
   logic halt_req;
   logic rst_take;
   logic irq_take;
   logic nmi_take;
   logic halt_take;
   modport ctl  (output exec_mode, emu_active, rst_req, irq_req, nmi_req,
                 halt_req, input rst_take, irq_take, nmi_take, halt_take);
   modport gate (input exec_mode, emu_active, rst_req, irq_req, nmi_req,
                 halt_req, output rst_take, irq_take, nmi_take, halt_take);
endinterface

/* File: rtl/emu_event_gate.sv */
/*
 holds reset, interrupt, nmi and halt requests pending during emulation halt.
 assumes requests are levels that stay up until taken.
*/
module emu_event_gate (
   // clock and reset
   input  wire logic core_clk_i,
   input  wire logic rst_n,
   // gated requests
   emu_hs_if.gate    g
);
   typedef struct packed {
      logic [3:0] take;
   } gate_s;
   gate_s st_reg;
   gate_s st_next;
   logic  open_w;

   always_comb begin
      st_next = st_reg;
      open_w  = !g.emu_active || g.exec_mode; // RULE1 RULE4
      st_next.take = open_w ? {g.halt_req, g.nmi_req, g.irq_req, g.rst_req}
                            : 4'h0; // RULE4
   end

   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign g.rst_take  = st_reg.take[0];
   assign g.irq_take  = st_reg.take[1];
   assign g.nmi_take  = st_reg.take[2];
   assign g.halt_take = st_reg.take[3];

   a_gate_halted: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      (g.emu_active && !g.exec_mode) |=> (st_reg.take == 4'h0)) // RULE4
      else $error("event taken during emulation halt");
   a_gate_open: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      (!g.emu_active && g.irq_req) |=> g.irq_take) // RULE1
      else $error("interrupt not passed while emulator idle");
endmodule

/* File: rtl/emu_access_hs.sv */
/*
 emulation access handshake: request, grant and host interrupt logic,
 plus execution gating of reset and interrupt events.
 assumes host register writes arrive as one-cycle strobes with data,
 and the emulator side presents a need level and a halt condition.
*/
module emu_access_hs (
   // clock and reset
   input  wire logic core_clk_i,
   input  wire logic rst_n_i,
   // host control word access
   input  wire logic host_ctrl_wr_i,
   input  wire logic host_grant_wdata_i,
   input  wire logic host_irqen_wdata_i,
   output logic [2:0] host_ctrl_low_reg_o,
   // emulator side
   input  wire logic emu_need_i,
   input  wire logic emu_active_i,
   input  wire logic emu_halt_cond_i,
   input  wire logic emu_resume_i,
   output logic      emu_go_o,
   output logic      exec_halted_o,
   // system events
   input  wire logic sys_rst_req_i,
   input  wire logic irq_req_i,
   input  wire logic nmi_req_i,
   input  wire logic host_halt_request_i,
   output logic      rst_take_o,
   output logic      irq_take_o,
   output logic      nmi_take_o,
   output logic      halt_take_o,
   // host interrupt, active low pin
   output logic      host_irq_out_n_o
);
   typedef struct packed {
      emu_hs_pkg::hs_state_e st;
      logic                  req;
      logic                  grant;
      logic                  irqen;
      logic                  irq_n;
      logic                  go;
      logic                  halted;
   } hs_s;
   hs_s        st_reg;
   hs_s        st_next;
   logic [1:0] rsync_reg;
   logic       rst_n;
   emu_hs_if gi ();

   // reset enters at once but leaves on a clock edge, so no flop sees a
   // release racing the clock; kept apart from the state it resets
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rsync_reg <= 2'h0;
      end else begin
         rsync_reg <= {rsync_reg[0], 1'b1};
      end
   end
   assign rst_n = rsync_reg[1];

   always_comb begin
      st_next = st_reg;
      if (host_ctrl_wr_i) begin
         st_next.grant = host_grant_wdata_i; // RULE16
         st_next.irqen = host_irqen_wdata_i; // RULE16
      end
      // a host write that changes grant, setting it to one or clearing it, drops the interrupt
      if (host_ctrl_wr_i && (host_grant_wdata_i != st_reg.grant)) begin
         st_next.irq_n = 1'b1; // RULE8 RULE13
      end
      // halt is immediate and independent of grant
      if (emu_halt_cond_i) begin
         st_next.halted = 1'b1; // RULE9
      end else if (emu_resume_i) begin
         st_next.halted = 1'b0;
      end
      case (st_reg.st)
         emu_hs_pkg::ST_IDLE: begin
            if (emu_need_i) begin
               st_next.req = 1'b1; // RULE6
               st_next.st  = emu_hs_pkg::ST_WAIT_GRANT;
               // a fresh edge beats a same-cycle clear
               if (st_reg.irqen) begin
                  st_next.irq_n = 1'b0; // RULE7
               end
            end
         end
         emu_hs_pkg::ST_WAIT_GRANT: begin
            if (st_reg.grant) begin
               st_next.st = emu_hs_pkg::ST_ACCESS; // RULE10
            end
         end
         emu_hs_pkg::ST_ACCESS: begin
            if (!emu_need_i) begin
               st_next.req = 1'b0; // RULE11
               st_next.st  = emu_hs_pkg::ST_WAIT_UNGRANT;
               if (st_reg.irqen) begin
                  st_next.irq_n = 1'b0; // RULE12
               end
            end
         end
         emu_hs_pkg::ST_WAIT_UNGRANT: begin
            if (!st_reg.grant) begin
               st_next.st = emu_hs_pkg::ST_IDLE;
            end
         end
         default: st_next.st = emu_hs_pkg::ST_IDLE;
      endcase
      st_next.go = (st_next.st == emu_hs_pkg::ST_ACCESS); // RULE10
   end

   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         st_reg.st     <= emu_hs_pkg::ST_IDLE;
         st_reg.req    <= 1'b0;
         st_reg.grant  <= 1'b0;
         st_reg.irqen  <= 1'b0;
         st_reg.irq_n  <= 1'b1;
         st_reg.go     <= 1'b0;
         st_reg.halted <= 1'b0;
      end else begin
         st_reg.st     <= st_next.st;
         st_reg.req    <= st_next.req;
         st_reg.grant  <= st_next.grant;
         st_reg.irqen  <= st_next.irqen;
         st_reg.irq_n  <= st_next.irq_n;
         st_reg.go     <= st_next.go;
         st_reg.halted <= st_next.halted;
      end
   end

   // the host port path is outside this block and is never stalled by it
   assign gi.exec_mode  = !st_reg.halted; // RULE3 RULE5
   assign gi.emu_active = emu_active_i;
   assign gi.rst_req    = sys_rst_req_i;
   assign gi.irq_req    = irq_req_i;
   assign gi.nmi_req    = nmi_req_i;
   assign gi.halt_req   = host_halt_request_i;

   emu_event_gate u_gate (
      .core_clk_i (core_clk_i),
      .rst_n      (rst_n),
      .g          (gi)
   );

   // outputs come straight from flip-flops
   assign host_ctrl_low_reg_o[emu_hs_pkg::REQ_BIT]   = st_reg.req; // RULE14
   assign host_ctrl_low_reg_o[emu_hs_pkg::GRANT_BIT] = st_reg.grant;
   assign host_ctrl_low_reg_o[emu_hs_pkg::IRQEN_BIT] = st_reg.irqen;
   assign emu_go_o         = st_reg.go;
   assign exec_halted_o    = st_reg.halted;
   assign host_irq_out_n_o = st_reg.irq_n;
   assign rst_take_o       = gi.rst_take;
   assign irq_take_o       = gi.irq_take;
   assign nmi_take_o       = gi.nmi_take;
   assign halt_take_o      = gi.halt_take;

   sequence s_req_rise;
      (st_reg.st == emu_hs_pkg::ST_IDLE) && emu_need_i && st_reg.irqen;
   endsequence
   sequence s_grant_write;
      host_ctrl_wr_i && host_grant_wdata_i && !st_reg.grant;
   endsequence

   a_req_sets: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      (st_reg.st == emu_hs_pkg::ST_IDLE && emu_need_i) |=> st_reg.req) // RULE6
      else $error("request flag not set");
   a_req_irq: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      s_req_rise |=> !host_irq_out_n_o) // RULE7
      else $error("no interrupt on request");
   // a request or release event in the same cycle wins over the clear
   a_grant_clears: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      s_grant_write ##0 !((st_reg.st == emu_hs_pkg::ST_IDLE) && emu_need_i
         && st_reg.irqen) ##0 !(emu_go_o && !emu_need_i && st_reg.irqen)
      |=> host_irq_out_n_o) // RULE8
      else $error("grant did not clear interrupt");
   // the host may withdraw grant mid-access; only the start is guarded
   a_no_go_ungranted: assert property (@(posedge core_clk_i)
      disable iff (!rst_n) $rose(emu_go_o) |-> $past(st_reg.grant)) // RULE10
      else $error("access began without grant");
   a_halt_now: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      emu_halt_cond_i |=> exec_halted_o) // RULE9
      else $error("halt not immediate");
   a_rel_clears: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      (emu_go_o && !emu_need_i) |=> !st_reg.req) // RULE11
      else $error("request flag not cleared");
   a_rel_irq: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      (emu_go_o && !emu_need_i && st_reg.irqen) |=> !host_irq_out_n_o) // RULE12
      else $error("no interrupt on release");
   a_ungrant_clr: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      (st_reg.st == emu_hs_pkg::ST_WAIT_UNGRANT && host_ctrl_wr_i
       && !host_grant_wdata_i && st_reg.grant) |=> host_irq_out_n_o) // RULE13
      else $error("ungrant did not clear interrupt");

   // host-side register behaviour
   a_host_write: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      host_ctrl_wr_i |=> (host_ctrl_low_reg_o[emu_hs_pkg::GRANT_BIT]
      == $past(host_grant_wdata_i))) // RULE16
      else $error("grant write did not land");
   a_req_readonly: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      (host_ctrl_wr_i && st_reg.st == emu_hs_pkg::ST_IDLE && !emu_need_i)
      |=> !st_reg.req) // RULE16
      else $error("host write reached request flag");
   a_req_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      (st_reg.st == emu_hs_pkg::ST_WAIT_GRANT) |=> st_reg.req) // RULE6
      else $error("request flag dropped while waiting");
   a_ungrant_idle: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      (st_reg.st == emu_hs_pkg::ST_WAIT_UNGRANT && !st_reg.grant)
      |=> (st_reg.st == emu_hs_pkg::ST_IDLE)) // RULE13
      else $error("handshake did not return to idle");
   // halt state follows only the emulator's own controls
   a_resume_run: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      (emu_resume_i && !emu_halt_cond_i) |=> !exec_halted_o) // RULE4
      else $error("resume did not restart execution");
   a_halt_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      (exec_halted_o && !emu_resume_i) |=> exec_halted_o) // RULE4
      else $error("halt left without resume");
endmodule

/* File: tb/host_model.sv */
/*
 host side model: polls the control word and writes the grant flag to
 follow the emulator request, and the enable flag to follow the bench.
 assumes a write lands one cycle after its one-cycle strobe.
*/
module host_model (
   // clock
   input  wire logic       core_clk_i,
   // bench control
   input  wire logic       hold_i,
   input  wire logic       irqen_i,
   // device control word
   input  wire logic [2:0] ctrl_i,
   // host write port
   output logic            wr_o,
   output logic            grant_o,
   output logic            irqen_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int unsigned quiet;
   initial begin
      wr_o = 1'b0;
      grant_o = 1'b0;
      irqen_o = 1'b0;
      quiet = 0;
   end
   // hold_i makes this host slow to answer, as a busy host would be
   always @(negedge core_clk_i) begin
      wr_o <= 1'b0;
      if (quiet != 0) begin
         quiet <= quiet - 1;
      end else if (!hold_i && (ctrl_i[0] !== ctrl_i[1] ||
                               ctrl_i[2] !== irqen_i)) begin
         wr_o <= 1'b1;
         grant_o <= ctrl_i[0];
         irqen_o <= irqen_i;
         quiet <= 2;
      end
   end
endmodule

/* File: tb/emulation_access_handshake_tb.sv */
/*
 bench for the emulation access handshake: host model on the host side,
 the bench plays the emulator and the event sources.
 assumes every effect shows one cycle after its sampling edge.
*/
module emulation_access_handshake_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic wr, gnt, ien, hold = 1'b0, irqen = 1'b0;
   logic [2:0] ctrl;
   logic need = 1'b0, act = 1'b0, hcond = 1'b0, resume = 1'b0;
   logic go, halted, irq_n;
   logic [3:0] req = 4'h0, take;
   int n_fail = 0, n_compared = 0;
   always #4 core_clk_i = ~core_clk_i;
   host_model u_host_model (.core_clk_i(core_clk_i), .hold_i(hold),
      .irqen_i(irqen), .ctrl_i(ctrl), .wr_o(wr), .grant_o(gnt),
      .irqen_o(ien));
   emu_access_hs u_emu_access_hs (.core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i), .host_ctrl_wr_i(wr), .host_grant_wdata_i(gnt),
      .host_irqen_wdata_i(ien), .host_ctrl_low_reg_o(ctrl),
      .emu_need_i(need), .emu_active_i(act), .emu_halt_cond_i(hcond),
      .emu_resume_i(resume), .emu_go_o(go), .exec_halted_o(halted),
      .sys_rst_req_i(req[3]), .irq_req_i(req[2]), .nmi_req_i(req[1]),
      .host_halt_request_i(req[0]), .rst_take_o(take[3]),
      .irq_take_o(take[2]), .nmi_take_o(take[1]), .halt_take_o(take[0]),
      .host_irq_out_n_o(irq_n));
   task automatic chk(input string what, input logic [3:0] e, g);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk_i);
   endtask
   task automatic wait_grant(input logic v);
      int i;
      for (i = 0; i < 20 && ctrl[1] !== v; i++) cyc(1);
      cyc(1);
   endtask
   task automatic wrap_up;
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic t_reset_vals;
      chk("ctrl", 4'h0, {1'b0, ctrl});
      chk("irq_n", 4'h1, {3'h0, irq_n});
      chk("go", 4'h0, {3'h0, go});
   endtask
   task automatic t_handshake;
      irqen = 1'b1;
      cyc(5);
      chk("ctrl", 4'h4, {1'b0, ctrl});
      hold = 1'b1;
      need = 1'b1;
      act = 1'b1;
      cyc(2);
      chk("ctrl", 4'h5, {1'b0, ctrl});
      chk("irq_n", 4'h0, {3'h0, irq_n});
      cyc(5);
      chk("go", 4'h0, {3'h0, go});
      hold = 1'b0;
      wait_grant(1'b1);
      chk("irq_n", 4'h1, {3'h0, irq_n});
      chk("go", 4'h1, {3'h0, go});
      hold = 1'b1;
      need = 1'b0;
      cyc(2);
      chk("ctrl", 4'h6, {1'b0, ctrl});
      chk("irq_n", 4'h0, {3'h0, irq_n});
      chk("go", 4'h0, {3'h0, go});
      hold = 1'b0;
      wait_grant(1'b0);
      chk("irq_n", 4'h1, {3'h0, irq_n});
   endtask
   task automatic t_no_irq;
      irqen = 1'b0;
      cyc(5);
      hold = 1'b1;
      need = 1'b1;
      cyc(3);
      chk("ctrl", 4'h1, {1'b0, ctrl});
      chk("irq_n", 4'h1, {3'h0, irq_n});
      need = 1'b0;
      cyc(2);
      hold = 1'b0;
      cyc(6);
   endtask
   task automatic t_gating;
      req = 4'hf;
      cyc(2);
      chk("takes", 4'hf, take);
      hcond = 1'b1;
      cyc(1);
      hcond = 1'b0;
      cyc(1);
      chk("halted", 4'h1, {3'h0, halted});
      chk("takes", 4'h0, take);
      irqen = 1'b1;
      cyc(5);
      chk("ctrl", 4'h4, {1'b0, ctrl});
      chk("takes", 4'h0, take);
      resume = 1'b1;
      cyc(1);
      resume = 1'b0;
      cyc(1);
      chk("halted", 4'h0, {3'h0, halted});
      chk("takes", 4'hf, take);
      act = 1'b0;
      hcond = 1'b1;
      cyc(1);
      hcond = 1'b0;
      cyc(1);
      chk("halted", 4'h1, {3'h0, halted});
      chk("takes", 4'hf, take);
      resume = 1'b1;
      cyc(1);
      resume = 1'b0;
      req = 4'h0;
      cyc(2);
   endtask
   initial begin
      cyc(12);
      rst_n_i = 1'b1;
      cyc(4);
      t_reset_vals();
      t_handshake();
      t_no_irq();
      t_gating();
      wrap_up();
   end
   // the run needs about a hundred cycles at most; 2000 leaves ample slack
   initial begin
      #16000;
      n_fail++;
      wrap_up();
   end
endmodule
